// ==== pmpcr_regs.sv ====
// Power management, energy-detect timers and PHY control registers.
// Assumes an APB master on the same clock and event pulses from the MAC.
// Operation
// RULE_01: Wake source field: 0001 energy, 0010 link up, 0100 magic, 1000 frame.
// RULE_02: Energy wake sets interrupt status bit 2, link-up wake sets bit 3.
// RULE_03: Wake pin asserts when a recorded event has its pin enable set.
// RULE_04: Wake bits clear only on power-up reset or write one.
// RULE_05: Wake pin deasserts once the wake bits are cleared.
// RULE_06: Two-bit mode field selects normal, energy, soft down, saving; resets zero.
// RULE_07: Energy mode has low and normal power states; energy wakes it.
// RULE_08: Soft power-down ends only on a read of the global reset register; here a PMEC write of another mode or a soft reset also ends it.
// RULE_09: Wake time counts continuous energy in 16 ms units, default 8.
// RULE_10: Sleep time counts continuous quiet in 1 s units, default 12.
// RULE_11: Host never programs either timer field to zero.
// RULE_12: Writing one to PHY reset bit pulses a reset; bit reads zero.
// RULE_13: Control bit 14 loops host transmit back to host receive.
// RULE_14: Bit 12 enables negotiation; when off bit 13 picks 100 or 10.
// RULE_15: Writing one to bit 9 restarts auto-negotiation.
// RULE_16: Bit 8 forces full or half duplex, default full.
// RULE_17: Bit 5 picks the crossover detection variant, default first.
// RULE_18: Bit 3 disables auto crossover; then bit 4 forces MDI or MDI-X.
// RULE_19: Bit 1 disables transmit, bit 0 disables LEDs, both default zero.
// RULE_20: Automatic wake from low power needs auto wake-up enable bit 7.
// RULE_21: Bit 12 sets wake pin polarity, high when set.
// RULE_22: Writing zero keeps wake bits; no write can set them.
`timescale 1ns/10ps
module pmpcr_regs
   import pmpcr_pkg::*;
#(
   parameter int WAKE_CYC = WAKE_UNIT_CYC,
   parameter int SLEEP_CYC = SLEEP_UNIT_CYC
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic softReset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire logic energyDetect,
   input wire logic linkUp,
   input wire logic magicPacket,
   input wire logic wakeFrame,
   output logic wakePin,
   output logic [1:0] powerMode,
   output logic lowPower,
   output logic phyReset,
   output pmpcr_phy_t phyCtl
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (WAKE_CYC < 1 || WAKE_CYC > 2 ** PRE_W || SLEEP_CYC < 1 || SLEEP_CYC > 2 ** PRE_W)
   begin : g_bad
      $error("Timer unit counts out of range.");
   end

   localparam logic [PRE_W-1:0] WAKE_LAST = PRE_W'(WAKE_CYC - 1);
   localparam logic [PRE_W-1:0] SLEEP_LAST = PRE_W'(SLEEP_CYC - 1);

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   function automatic logic isMapped(logic [9:0] i);
      if (i == IDX_PMEC || i == IDX_TIMER || i == IDX_PHYRST || i == IDX_BCTL)
      begin
         return 1'b1;
      end
      else if (i == IDX_IRQ || i == IDX_GRR || i == IDX_PSTAT)
      begin
         return 1'b1;
      end
      else
      begin
         return 1'b0;
      end
   endfunction : isMapped

   function automatic logic [15:0] readReg(pmpcr_state_t s, logic [9:0] i);
      if (i == IDX_PMEC)
      begin
         return {s.pmec[15:6], s.wakeEvt, s.pmec[1:0]};
      end
      else if (i == IDX_TIMER)
      begin
         return s.timer;
      end
      else if (i == IDX_PHYRST)
      begin
         return s.phyRst;
      end
      else if (i == IDX_BCTL)
      begin
         return s.bctl;
      end
      else if (i == IDX_IRQ)
      begin
         return {12'h0000, s.irq, 2'h0};
      end
      else if (i == IDX_PSTAT)
      begin
         return {15'h0000, s.pwr == PWR_LOW};
      end
      else
      begin
         return 16'h0000;
      end
   endfunction : readReg

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   pmpcr_state_t s_r;
   pmpcr_state_t s_nxt;
   logic [9:0] idx;
   logic commit;
   logic energyLvl;
   logic [3:0] evSet;
   logic [1:0] mode;

   assign idx = paddr[11:2];
   assign commit = psel & penable & s_r.pready;
   assign energyLvl = s_r.enSync[1];
   assign mode = s_r.pmec[1:0];

   // Next state: bus access, timers, event capture and pin drive.
   always_comb
   begin
      s_nxt = s_r;
      evSet = 4'h0;
      s_nxt.enSync = {s_r.enSync[1:0], energyDetect};
      s_nxt.lkSync = {s_r.lkSync[1:0], linkUp};
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.phyRstPulse = 1'b0;
      s_nxt.anRstPulse = 1'b0;

      // One wait state keeps read data and pready straight from flops.
      if (psel && penable && !s_r.pready)
      begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = !isMapped(idx);
         s_nxt.prdata = {16'h0000, readReg(s_r, idx)};
      end

      // Register writes take effect only at the completing edge.
      if (commit && pwrite)
      begin
         if (idx == IDX_PMEC)
         begin
            s_nxt.pmec = pwdata[15:0] & PMEC_WMASK; // RULE_06
            s_nxt.wakeEvt = s_r.wakeEvt & ~pwdata[5:2]; // RULE_04 RULE_22
         end
         else if (idx == IDX_TIMER)
         begin
            s_nxt.timer = pwdata[15:0]; // RULE_09 RULE_10
         end
         else if (idx == IDX_PHYRST)
         begin
            s_nxt.phyRst = pwdata[15:0] & PHYRST_WMASK;
            s_nxt.phyRstPulse = pwdata[0]; // RULE_12
         end
         else if (idx == IDX_BCTL)
         begin
            s_nxt.bctl = pwdata[15:0] & BCTL_WMASK;
            s_nxt.anRstPulse = pwdata[BC_ANRST]; // RULE_15
         end
         else if (idx == IDX_IRQ)
         begin
            s_nxt.irq = s_r.irq & ~pwdata[3:2];
         end
      end

      // A read of the global reset register ends soft power-down, as do a PMEC write of another mode and a soft reset.
      if (commit && !pwrite && idx == IDX_GRR && mode == MODE_SOFTPD)
      begin
         s_nxt.pmec[1:0] = MODE_NORMAL; // RULE_08
      end

      // Energy detect: quiet time sends it to sleep, energy time wakes it.
      if (mode != MODE_ENERGY)
      begin
         s_nxt.pwr = PWR_NORMAL;
         s_nxt.pre = '0;
         s_nxt.units = 8'h00;
      end
      else
      begin
         case (s_r.pwr)
            PWR_NORMAL:
            begin
               if (energyLvl)
               begin
                  s_nxt.pre = '0;
                  s_nxt.units = 8'h00;
               end
               else if (s_r.pre != SLEEP_LAST)
               begin
                  s_nxt.pre = s_r.pre + 1'b1;
               end
               else if (s_r.units + 8'h01 == s_r.timer[7:0])
               begin
                  s_nxt.pwr = PWR_LOW; // RULE_10 RULE_07
                  s_nxt.pre = '0;
                  s_nxt.units = 8'h00;
               end
               else
               begin
                  s_nxt.pre = '0;
                  s_nxt.units = s_r.units + 8'h01;
               end
            end
            PWR_LOW:
            begin
               if (!energyLvl)
               begin
                  s_nxt.pre = '0;
                  s_nxt.units = 8'h00;
               end
               else if (s_r.pre != WAKE_LAST)
               begin
                  s_nxt.pre = s_r.pre + 1'b1;
               end
               else if (s_r.units + 8'h01 == s_r.timer[15:8])
               begin
                  evSet[0] = 1'b1; // RULE_09 RULE_01
                  if (s_r.pmec[PM_AUTOWK])
                  begin
                     s_nxt.pwr = PWR_NORMAL; // RULE_20 RULE_07
                  end
                  s_nxt.pre = '0;
                  s_nxt.units = 8'h00;
               end
               else
               begin
                  s_nxt.pre = '0;
                  s_nxt.units = s_r.units + 8'h01;
               end
            end
            default:
            begin
               s_nxt.pwr = PWR_NORMAL;
            end
         endcase
      end

      // Other wake sources count only while a power mode is active.
      if (mode != MODE_NORMAL)
      begin
         evSet[1] = s_r.lkSync[1] & ~s_r.lkSync[2]; // RULE_01
         evSet[2] = magicPacket;
         evSet[3] = wakeFrame;
      end

      // A soft reset restores control state but leaves the wake bits.
      if (softReset)
      begin
         s_nxt.pmec = PMEC_RST;
         s_nxt.timer = TIMER_RST;
         s_nxt.phyRst = PHYRST_RST;
         s_nxt.bctl = BCTL_RST;
         s_nxt.irq = 2'h0;
         s_nxt.pwr = PWR_NORMAL;
         s_nxt.pre = '0;
         s_nxt.units = 8'h00; // RULE_04
      end

      // Setting wins over a clear in the same cycle.
      s_nxt.wakeEvt = s_nxt.wakeEvt | evSet; // RULE_01 RULE_22
      s_nxt.irq = s_nxt.irq | evSet[1:0]; // RULE_02

      // Pin follows the stored bits, so clearing them drops it.
      s_nxt.wakePin = (|(s_nxt.wakeEvt & s_nxt.pmec[11:8]))
         ~^ s_nxt.pmec[PM_POL]; // RULE_03 RULE_05 RULE_21
   end

   // Single register stage; clock enable freezes everything but reset.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         s_r <= ST_RST;
      end
      else if (ce)
      begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign prdata = s_r.prdata;
   assign wakePin = s_r.wakePin;
   assign powerMode = s_r.pmec[1:0]; // RULE_06
   assign lowPower = s_r.pwr == PWR_LOW;
   assign phyReset = s_r.phyRstPulse; // RULE_12
   assign phyCtl.loopback = s_r.bctl[BC_LOOP]; // RULE_13
   assign phyCtl.force100 = s_r.bctl[BC_F100]; // RULE_14
   assign phyCtl.anEnable = s_r.bctl[BC_ANEN]; // RULE_14
   assign phyCtl.anRestart = s_r.anRstPulse; // RULE_15
   assign phyCtl.fullDuplex = s_r.bctl[BC_FDX]; // RULE_16
   assign phyCtl.xoverAlg = s_r.bctl[BC_XALG]; // RULE_17
   assign phyCtl.xoverDisable = s_r.bctl[BC_XDIS]; // RULE_18
   assign phyCtl.forceMdi = s_r.bctl[BC_FMDI]; // RULE_18
   assign phyCtl.txDisable = s_r.bctl[BC_TXDIS]; // RULE_19
   assign phyCtl.ledDisable = s_r.bctl[BC_LEDDIS]; // RULE_19

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   logic wrPm;
   assign wrPm = commit && pwrite && idx == IDX_PMEC && !softReset;

   a_evt_no_set: assert property ( // RULE_22
      ce |=> ((s_r.wakeEvt & ~$past(s_r.wakeEvt) & ~$past(evSet)) == 4'h0))
      else $error("Wake bit rose without an event.");

   a_evt_soft_keep: assert property ( // RULE_04
      ce && softReset && !(commit && pwrite && idx == IDX_PMEC)
      |=> (($past(s_r.wakeEvt) & ~s_r.wakeEvt) == 4'h0))
      else $error("Soft reset lost a wake bit.");

   a_pin_enabled: assert property ( // RULE_03
      (|(s_r.wakeEvt & s_r.pmec[11:8])) |-> s_r.wakePin == s_r.pmec[PM_POL])
      else $error("Wake pin not asserted for enabled event.");

   a_pin_clear: assert property ( // RULE_05
      ce && wrPm && (s_r.wakeEvt & ~pwdata[5:2]) == 4'h0 && evSet == 4'h0
      |=> s_r.wakePin == !s_r.pmec[PM_POL])
      else $error("Wake pin still active after clear.");

   a_pin_polarity: assert property ( // RULE_21
      s_r.wakeEvt == 4'h0 |-> s_r.wakePin == !s_r.pmec[PM_POL])
      else $error("Idle wake pin has wrong polarity.");

   a_irq_event: assert property ( // RULE_02
      ce && (evSet[0] || evSet[1]) |=> (s_r.irq & $past(evSet[1:0])) == $past(evSet[1:0]))
      else $error("Interrupt status not set with wake event.");

   a_mode_write: assert property ( // RULE_06
      ce && wrPm |=> s_r.pmec[1:0] == $past(pwdata[1:0]))
      else $error("Mode field did not take the write.");

   a_soft_wake: assert property ( // RULE_08
      ce && commit && !pwrite && idx == IDX_GRR && mode == MODE_SOFTPD && !softReset
      |=> powerMode == MODE_NORMAL)
      else $error("Global reset read did not end soft power-down.");

   a_phy_pulse: assert property ( // RULE_12
      ce && commit && pwrite && idx == IDX_PHYRST && pwdata[0] |=> phyReset ##1 (!phyReset || !ce))
      else $error("PHY reset pulse wrong.");

   a_sleep_time: assert property ( // RULE_10
      s_r.pwr == PWR_NORMAL ##1 s_r.pwr == PWR_LOW
      |-> $past(s_r.units) + 8'h01 == $past(s_r.timer[7:0]) && !$past(energyLvl))
      else $error("Sleep entered before quiet time.");

   a_wake_time: assert property ( // RULE_09
      ce && evSet[0] |-> s_r.units + 8'h01 == s_r.timer[15:8] && energyLvl)
      else $error("Energy wake before wake time.");

   a_wake_auto: assert property ( // RULE_20
      s_r.pwr == PWR_LOW ##1 s_r.pwr == PWR_NORMAL
      |-> $past(s_r.pmec[PM_AUTOWK]) || $past(mode) != MODE_ENERGY || $past(softReset))
      else $error("Woke without auto wake-up enable.");

   c_sleep: cover property (s_r.pwr == PWR_NORMAL ##1 s_r.pwr == PWR_LOW);
   c_energy_wake: cover property (ce && evSet[0] && s_r.pmec[PM_AUTOWK]);
   c_soft_exit: cover property (mode == MODE_SOFTPD ##1 mode == MODE_NORMAL);
   c_pin_on: cover property (|(s_r.wakeEvt & s_r.pmec[11:8]));

endmodule : pmpcr_regs

// ==== pmpcr_pkg.sv ====
// Package for the power management and PHY control register bank.
// Assumes a single 20 MHz clock and a 12-bit APB byte address.
package pmpcr_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int WAKE_UNIT_MS = 16;
   localparam int SLEEP_UNIT_S = 1;
   localparam int WAKE_UNIT_CYC = WAKE_UNIT_MS * 1000 * CLK_MHZ;
   localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_S * 1000000 * CLK_MHZ;
   localparam int PRE_W = 25;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [9:0] IDX_PMEC = 10'h0d4;
   localparam logic [9:0] IDX_TIMER = 10'h0d6;
   localparam logic [9:0] IDX_PHYRST = 10'h0d8;
   localparam logic [9:0] IDX_BCTL = 10'h0e4;
   localparam logic [9:0] IDX_IRQ = 10'h0f0;
   localparam logic [9:0] IDX_GRR = 10'h0f2;
   localparam logic [9:0] IDX_PSTAT = 10'h0f4;

   // ------------------------------------------------------------------
   // Field positions, masks and reset values
   // ------------------------------------------------------------------
   localparam int PM_POL = 12;
   localparam int PM_AUTOWK = 7;
   localparam int BC_LOOP = 14;
   localparam int BC_F100 = 13;
   localparam int BC_ANEN = 12;
   localparam int BC_ANRST = 9;
   localparam int BC_FDX = 8;
   localparam int BC_XALG = 5;
   localparam int BC_FMDI = 4;
   localparam int BC_XDIS = 3;
   localparam int BC_TXDIS = 1;
   localparam int BC_LEDDIS = 0;
   localparam logic [15:0] PMEC_WMASK = 16'h7fc3;
   localparam logic [15:0] BCTL_WMASK = 16'h7d3f;
   localparam logic [15:0] PHYRST_WMASK = 16'hfffe;
   localparam logic [15:0] PMEC_RST = 16'h0000;
   localparam logic [15:0] TIMER_RST = 16'h080c;
   localparam logic [15:0] BCTL_RST = 16'h3120;
   localparam logic [15:0] PHYRST_RST = 16'h0000;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_ENERGY = 2'h1;
   localparam logic [1:0] MODE_SOFTPD = 2'h2;
   localparam logic [1:0] MODE_SAVING = 2'h3;

   typedef enum logic {PWR_NORMAL, PWR_LOW} pmpcr_pwr_t;

   typedef struct packed {
      logic loopback;
      logic force100;
      logic anEnable;
      logic anRestart;
      logic fullDuplex;
      logic xoverAlg;
      logic xoverDisable;
      logic forceMdi;
      logic txDisable;
      logic ledDisable;
   } pmpcr_phy_t;

   typedef struct packed {
      logic [15:0] pmec;
      logic [3:0] wakeEvt;
      logic [15:0] timer;
      logic [15:0] phyRst;
      logic [15:0] bctl;
      logic [1:0] irq;
      pmpcr_pwr_t pwr;
      logic [PRE_W-1:0] pre;
      logic [7:0] units;
      logic [2:0] enSync;
      logic [2:0] lkSync;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic wakePin;
      logic phyRstPulse;
      logic anRstPulse;
   } pmpcr_state_t;

   localparam pmpcr_state_t ST_RST = '{pmec: PMEC_RST, timer: TIMER_RST,
      phyRst: PHYRST_RST, bctl: BCTL_RST, pwr: PWR_NORMAL, wakePin: 1'b1,
      default: '0};

endpackage : pmpcr_pkg

// ==== tb_pmpcr_regs.sv ====
// Self-checking testbench for the power management and PHY control register bank.
// Assumes pmpcr_pkg and pmpcr_regs are compiled first; one 20 MHz clock drives all.
`timescale 1ns/10ps

`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp); \
      end \
   end

module tb_pmpcr_regs
   import pmpcr_pkg::*;
;
   // ------------------------------------------------------------------
   // Signals and constants
   // ------------------------------------------------------------------
   // Short unit counts keep the sleep and wake periods to a few cycles.
   localparam int WK = 4;
   localparam int SL = 6;
   localparam logic [11:0] A_PMEC = {IDX_PMEC, 2'b00};
   localparam logic [11:0] A_TIMER = {IDX_TIMER, 2'b00};
   localparam logic [11:0] A_PHYRST = {IDX_PHYRST, 2'b00};
   localparam logic [11:0] A_BCTL = {IDX_BCTL, 2'b00};
   localparam logic [11:0] A_IRQ = {IDX_IRQ, 2'b00};
   localparam logic [11:0] A_GRR = {IDX_GRR, 2'b00};
   localparam logic [11:0] A_PSTAT = {IDX_PSTAT, 2'b00};
   logic clock, rst_b, ce, softReset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic energyDetect, linkUp, magicPacket, wakeFrame, wakePin, lowPower, phyReset, e;
   logic [1:0] powerMode;
   pmpcr_phy_t phyCtl;
   logic [15:0] w;
   logic [15:0] pat [5] = '{16'hc000, 16'h2000, 16'h1100, 16'h0038, 16'h0c07};
   int errors, comparisons, n, k;

   pmpcr_regs #(.WAKE_CYC(WK), .SLEEP_CYC(SL)) pmpcr_regs_inst (.clock(clock), .rst_b(rst_b),
      .ce(ce), .softReset(softReset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .energyDetect(energyDetect), .linkUp(linkUp), .magicPacket(magicPacket),
      .wakeFrame(wakeFrame), .wakePin(wakePin), .powerMode(powerMode),
      .lowPower(lowPower), .phyReset(phyReset), .phyCtl(phyCtl));

   // Free-running 50 ns clock.
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task report_and_stop;
      $display("Comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd);
      int t;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, wd};
      t = 0;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         t++;
      end
      while (pready !== 1'b1 && t < 20);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         errors++;
         report_and_stop();
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [15:0] wd);
      apb(1'b1, a, wd);
   endtask : wr

   // Reads a register and compares data and error response.
   task automatic rdc(input logic [11:0] a, input logic [15:0] x, input logic xe = 1'b0);
      apb(1'b0, a, 16'h0000);
      `CHK(d, {16'h0000, x})
      `CHK(e, xe)
   endtask : rdc

   // Waits, bounded, until the low power state equals v; n counts the cycles.
   task automatic wait_lp(input logic v);
      n = 0;
      while (lowPower !== v && n < 100)
      begin
         @(posedge clock);
         n++;
      end
      if (lowPower !== v)
      begin
         errors++;
         report_and_stop();
      end
   endtask : wait_lp

   // Counts self-clearing pulses on the PHY reset and restart outputs.
   task automatic count_pulses;
      n = 0;
      repeat (4)
      begin
         @(posedge clock);
         n += int'(phyReset | phyCtl.anRestart);
      end
   endtask : count_pulses

   // Raises one wake source: 1 link up, 2 magic packet, 3 wake-up frame.
   task automatic pulse(input int s);
      @(posedge clock);
      linkUp <= (s == 1);
      magicPacket <= (s == 2);
      wakeFrame <= (s == 3);
      @(posedge clock);
      magicPacket <= 1'b0;
      wakeFrame <= 1'b0;
      repeat (5) @(posedge clock);
      linkUp <= 1'b0;
   endtask : pulse

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      {rst_b, softReset, psel, penable, pwrite, linkUp, magicPacket, wakeFrame} = '0;
      ce = 1'b1;
      energyDetect = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      errors = 0;
      comparisons = 0;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      // Reset values, then an unmapped word answers with an error.
      `CHK(wakePin, 1'b1)
      `CHK(powerMode, MODE_NORMAL)
      `CHK(phyCtl, 10'h1b0)
      rdc(A_PMEC, PMEC_RST);
      rdc(A_TIMER, 16'h080c);
      rdc(A_PHYRST, 16'h0000);
      rdc(A_BCTL, 16'h3120);
      rdc(12'h3fc, 16'h0000, 1'b1);
      $display("Test reset values done");
      // Control fields reach the PHY outputs; read-only bits stay zero.
      foreach (pat[i])
      begin
         w = pat[i];
         wr(A_BCTL, w);
         @(posedge clock);
         `CHK(phyCtl, {w[14:12], 1'b0, w[8], w[5], w[3], w[4], w[1:0]})
         rdc(A_BCTL, w & BCTL_WMASK);
      end
      wr(A_BCTL, 16'h1200);
      count_pulses();
      `CHK(n, 1)
      rdc(A_BCTL, 16'h1000);
      wr(A_PHYRST, 16'h0003);
      count_pulses();
      `CHK(n, 1)
      rdc(A_PHYRST, 16'h0002);
      $display("Test PHY control done");
      // Every mode value; soft power-down holds over other reads and ends on the global reset read.
      for (k = 0; k < 4; k++)
      begin
         wr(A_PMEC, 16'(k));
         @(posedge clock);
         `CHK(powerMode, 2'(k))
      end
      wr(A_PMEC, 16'h0002);
      rdc(A_TIMER, 16'h080c);
      rdc(A_PMEC, 16'h0002);
      rdc(A_GRR, 16'h0000);
      rdc(A_PMEC, 16'h0000);
      $display("Test modes done");
      // Link-up, magic and frame sources, their pin enables, write-zero hold and write-one clear.
      for (k = 1; k < 4; k++)
      begin
         w = 16'h1003 | (16'h0100 << k);
         wr(A_PMEC, w);
         // The pin is launched by the completing edge, so look one edge later.
         @(posedge clock);
         `CHK(wakePin, 1'b0)
         pulse(k);
         rdc(A_PMEC, w | (16'h0004 << k));
         `CHK(wakePin, 1'b1)
         wr(A_PMEC, w);
         rdc(A_PMEC, w | (16'h0004 << k));
         rdc(A_IRQ, (k == 1) ? 16'h0008 : 16'h0000);
         wr(A_IRQ, 16'h000c);
         wr(A_PMEC, w | (16'h0004 << k));
         rdc(A_PMEC, w);
         `CHK(wakePin, 1'b0)
      end
      // Disabled pin, soft reset keeps the event, active-low pin polarity.
      wr(A_PMEC, 16'h0003);
      pulse(2);
      `CHK(wakePin, 1'b1)
      softReset <= 1'b1;
      @(posedge clock);
      softReset <= 1'b0;
      rdc(A_PMEC, 16'h0010);
      wr(A_PMEC, 16'h0403);
      @(posedge clock);
      `CHK(wakePin, 1'b0)
      wr(A_PMEC, 16'h0413);
      @(posedge clock);
      `CHK(wakePin, 1'b1)
      wr(A_PMEC, 16'h0200);
      pulse(1);
      rdc(A_PMEC, 16'h0200);
      $display("Test wake events done");
      // Energy detect: go to sleep after quiet, wake after steady energy.
      wr(A_TIMER, 16'h0201);
      rdc(A_TIMER, 16'h0201);
      wr(A_PMEC, 16'h1181);
      energyDetect <= 1'b0;
      wait_lp(1'b1);
      `CHK(n >= SL, 1'b1)
      energyDetect <= 1'b1;
      wait_lp(1'b0);
      `CHK(n >= 2 * WK, 1'b1)
      rdc(A_PMEC, 16'h1185);
      `CHK(wakePin, 1'b1)
      rdc(A_IRQ, 16'h0004);
      wr(A_IRQ, 16'h0004);
      wr(A_PMEC, 16'h1105);
      energyDetect <= 1'b0;
      wait_lp(1'b1);
      energyDetect <= 1'b1;
      repeat (60) @(posedge clock);
      `CHK(lowPower, 1'b1)
      rdc(A_PSTAT, 16'h0001);
      rdc(A_PMEC, 16'h1105);
      wr(A_PMEC, 16'h0007);
      $display("Test energy detect done");
      // Power-up reset clears a recorded event.
      wr(A_PMEC, 16'h0003);
      pulse(3);
      rst_b <= 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      rdc(A_PMEC, 16'h0000);
      $display("Test power-up reset done");
      report_and_stop();
   end

endmodule : tb_pmpcr_regs
